// ### far_end_line.sv
`timescale 1ns/1ps
module far_end_line (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       send,
    input  wire logic [7:0] code,
    input  wire logic [3:0] len,
    output logic            rx_line_data
);
    // ----------------------------------------------------------------
    // repeating code, msb first, toggling filler when silent
    // ----------------------------------------------------------------
    logic [1:0] div;
    logic [3:0] idx;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div <= 2'h0;
            idx <= 4'h0;
            rx_line_data <= 1'b0;
        end else begin
            div <= div + 2'h1;
            if (div == 2'h3) begin
                idx <= (idx == 4'h0) ? len - 4'h1 : idx - 4'h1;
                rx_line_data <= send ? code[idx[2:0]] : ~rx_line_data;
            end
        end
    end
endmodule : far_end_line

// ### inband_code_detect.sv
`timescale 1ns/1ps
`include "lbc_defines.svh"
module inband_code_detect
    import lbc_pkg::*;
(
    input wire logic         hclk,
    input wire logic         hresetn,
    lbc_detect_if.detector   det
);
    det_state_t st;
    det_state_t next_st;
    logic [3:0] len;
    logic       hit;

    // two aligned back-to-back copies of the code in the history
    function automatic logic code_match(input logic [15:0] h, input logic [7:0] c,
                                        input logic [3:0] l);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < 8; i++) begin
            if (i < int'(l)) begin
                if (h[i] != c[i] || h[i + int'(l)] != c[i]) begin
                    ok = 1'b0;
                end
            end
        end
        return ok;
    endfunction : code_match

    always_comb begin
        next_st = st;
        len     = code_len_of(det.len_sel);
        hit     = 1'b0;
        if (det.bit_en) begin
            next_st.hist = {st.hist[14:0], det.rx_bit};
            hit          = code_match(next_st.hist, det.code, len);
            if (hit) begin
                next_st.gap = 4'h0;
                if (st.run_cnt != `DETECT_REPEATS) begin
                    next_st.run_cnt = st.run_cnt + 8'h01;
                end
            end else begin
                next_st.gap = st.gap + 4'h1;
                if (next_st.gap >= len) begin
                    next_st.run_cnt = 8'h00;
                    next_st.gap     = 4'h0;
                end
            end
        end
        next_st.detected = (next_st.run_cnt == `DETECT_REPEATS);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign det.detected = st.detected;

endmodule : inband_code_detect

// ### lbc_chk.sv
`timescale 1ns/1ps
`include "lbc_defines.svh"
module lbc_chk (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        rx_line_data,
    input wire logic        tx_data_in,
    input wire logic        tx_line_data,
    input wire logic        rx_data_out,
    input wire logic        digital_loopback_active,
    input wire logic        analog_loopback_active,
    input wire logic        remote_loopback_active
);
    // ----------------------------------------------------------------
    // transfer decode
    // ----------------------------------------------------------------
    logic rd_take;
    logic wr_ctrl;
    assign rd_take = hsel && hready && htrans[1] && !hwrite;
    assign wr_ctrl = hsel && hready && htrans[1] && hwrite && (haddr == {25'h0, `IDX_LOOP_CTRL, 2'h0});

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_read_wait:
        assert property (rd_take |=> !hreadyout ##1 hreadyout) else $error("read wait state not one cycle");
    a_resp_okay:
        assert property (hresp == 1'b0) else $error("response not okay");
    a_digital_set:
        assert property (wr_ctrl |-> ##3 (digital_loopback_active == $past(hwdata[0], 2)))
        else $error("digital loopback flag wrong");
    a_analog_set:
        assert property (wr_ctrl |-> ##3 (analog_loopback_active == $past(hwdata[1], 2)))
        else $error("analog loopback flag wrong");
    a_remote_set:
        assert property (wr_ctrl ##1 hwdata[2] |-> ##2 remote_loopback_active) else $error("remote loopback not set");
    a_remote_clear:
        assert property (wr_ctrl ##1 (hwdata[3:2] == 2'h0) |-> ##3 !remote_loopback_active)
        else $error("remote loopback not cleared");
    a_rx_digital:
        assert property (digital_loopback_active && $past(digital_loopback_active) && $past(hresetn)
                         |-> rx_data_out == $past(tx_data_in)) else $error("digital loop data wrong");
    a_rx_normal:
        assert property (!digital_loopback_active && !$past(digital_loopback_active) && $past(hresetn)
                         |-> rx_data_out == $past(rx_line_data)) else $error("receive data wrong");
    a_tx_hold:
        assert property ($changed(tx_line_data) |=> $stable(tx_line_data) [*3]) else $error("line bit too short");
    a_reset_clear:
        assert property ($rose(hresetn) |-> !digital_loopback_active && !analog_loopback_active
                         && !remote_loopback_active) else $error("loopback set after reset");

    c_read:   cover property (rd_take);
    c_remote: cover property ($rose(remote_loopback_active));
    c_digit:  cover property (digital_loopback_active);
endmodule : lbc_chk

bind loopback_and_inband_code_config lbc_chk u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .rx_line_data(rx_line_data),
    .tx_data_in(tx_data_in), .tx_line_data(tx_line_data), .rx_data_out(rx_data_out),
    .digital_loopback_active(digital_loopback_active), .analog_loopback_active(analog_loopback_active),
    .remote_loopback_active(remote_loopback_active)
);

// ### lbc_defines.svh
`ifndef LBC_DEFINES_SVH
`define LBC_DEFINES_SVH

// ----------------------------------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------------------------------
`define IDX_PATTERN      5'h0A
`define IDX_LOOP_CTRL    5'h0B
`define IDX_CODE_LEN     5'h0C
`define IDX_TX_CODE      5'h0D
`define IDX_ACT_CODE     5'h0E
`define IDX_DEACT_CODE   5'h0F
`define IDX_STATUS       5'h1F

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_LOOP_CTRL    4'h0
`define RST_CODE_LEN     6'h01
`define RST_TX_CODE      8'h01
`define RST_ACT_CODE     8'h01
`define RST_DEACT_CODE   8'h09
`define RST_PATTERN      2'h0

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define FLD_DIGITAL      0
`define FLD_ANALOG       1
`define FLD_REMOTE       2
`define FLD_AUTO         3
`define FLD_DEACT_LEN    0
`define FLD_ACT_LEN      2
`define FLD_TX_LEN       4
`define FLD_PATTERN      5
`define FLD_WORD_IDX     2
`define FLD_ADDR_TOP     7
`define FLD_HTRANS_ACT   1

// ----------------------------------------------------------------
// encodings and timing
// ----------------------------------------------------------------
`define PATTERN_ALL_ONES 2'h1
`define PATTERN_INBAND   2'h3
`define CODE_LEN_MIN     4'h5
`define CLK_PERIOD_NS    100
`define LINE_BIT_NS      400
`define LINE_BIT_CYCLES  ((`LINE_BIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DETECT_REPEATS   8'h10

`endif

// ### lbc_detect_if.sv
`timescale 1ns/1ps
interface lbc_detect_if;
    logic       bit_en;
    logic       rx_bit;
    logic [7:0] code;
    logic [1:0] len_sel;
    logic       detected;

    modport detector (
        input  bit_en,
        input  rx_bit,
        input  code,
        input  len_sel,
        output detected
    );
    modport owner (
        output bit_en,
        output rx_bit,
        output code,
        output len_sel,
        input  detected
    );
endinterface : lbc_detect_if

// ### lbc_pkg.sv
package lbc_pkg;

    typedef enum logic [1:0] {
        LOOP_IDLE = 2'b01,
        LOOP_AUTO = 2'b10
    } auto_state_t;

    typedef struct packed {
        logic [3:0]  loop_ctrl;
        logic [5:0]  code_len;
        logic [7:0]  tx_code;
        logic [7:0]  act_code;
        logic [7:0]  deact_code;
        logic [1:0]  pattern;
        auto_state_t auto_state;
        logic [2:0]  div_cnt;
        logic        bit_en;
        logic [2:0]  tx_idx;
        logic        tx_line_data;
        logic        rx_data_out;
        logic        digital_loop;
        logic        analog_loop;
        logic        remote_loop;
        logic        wr_pend;
        logic        rd_pend;
        logic        dp_ok;
        logic [4:0]  dp_idx;
        logic        hreadyout;
        logic [31:0] hrdata;
        logic        hresp;
    } top_state_t;

    typedef struct packed {
        logic [15:0] hist;
        logic [7:0]  run_cnt;
        logic [3:0]  gap;
        logic        detected;
    } det_state_t;

    function automatic logic [3:0] code_len_of(input logic [1:0] sel);
        return 4'h5 + {2'h0, sel};
    endfunction : code_len_of

endpackage : lbc_pkg

// ### loopback_and_inband_code_config.sv
// Contract
// - auto remote loopback enable bit permits automatic entry into remote loopback
// - remote loopback enable bit places the channel in remote loopback
// - analog loopback enable bit turns analog loopback on
// - digital loopback enable bit turns digital loopback on
// - transmit code length field selects 5 to 8 bits, resets to 5
// - receive activate length field selects 5 to 8 bits, resets to 5
// - receive deactivate length field selects 5 to 8 bits, resets to 6
// - transmit code uses low bits of its register, repeating, default 00001
// - activate code matched repeating from low register bits, default 00001
// - deactivate code matched repeating from low register bits, default 001001
// - reserved upper control bits and all loopback enables reset to zero
// - pattern select 11 inserts repeating in-band code into transmit stream
`timescale 1ns/1ps
`include "lbc_defines.svh"
module loopback_and_inband_code_config
    import lbc_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    input  wire logic        rx_line_data,
    input  wire logic        tx_data_in,
    output logic             tx_line_data,
    output logic             rx_data_out,
    output logic             digital_loopback_active,
    output logic             analog_loopback_active,
    output logic             remote_loopback_active
);
    // ----------------------------------------------------------------
    // reset state
    // ----------------------------------------------------------------
    localparam top_state_t ST_RESET = '{
        loop_ctrl:    `RST_LOOP_CTRL,
        code_len:     `RST_CODE_LEN,
        tx_code:      `RST_TX_CODE,
        act_code:     `RST_ACT_CODE,
        deact_code:   `RST_DEACT_CODE,
        pattern:      `RST_PATTERN,
        auto_state:   LOOP_IDLE,
        div_cnt:      3'h0,
        bit_en:       1'b0,
        tx_idx:       3'h0,
        tx_line_data: 1'b0,
        rx_data_out:  1'b0,
        digital_loop: 1'b0,
        analog_loop:  1'b0,
        remote_loop:  1'b0,
        wr_pend:      1'b0,
        rd_pend:      1'b0,
        dp_ok:        1'b0,
        dp_idx:       5'h00,
        hreadyout:    1'b1,
        hrdata:       32'h00000000,
        hresp:        1'b0
    };
    localparam logic [2:0] BIT_CYCLES = 3'(`LINE_BIT_CYCLES);

    // ----------------------------------------------------------------
    // state and working signals
    // ----------------------------------------------------------------
    top_state_t   st;
    top_state_t   next_st;
    logic         addr_ok;
    logic         auto_en;
    logic         remote_now;
    logic [3:0]   tx_len;
    logic [4:0]   a_idx;

    lbc_detect_if act_if ();
    lbc_detect_if deact_if ();

    // ----------------------------------------------------------------
    // register decode
    // ----------------------------------------------------------------
    function automatic logic idx_mapped(input logic [4:0] idx);
        return idx == `IDX_PATTERN
            || idx == `IDX_LOOP_CTRL
            || idx == `IDX_CODE_LEN
            || idx == `IDX_TX_CODE
            || idx == `IDX_ACT_CODE
            || idx == `IDX_DEACT_CODE
            || idx == `IDX_STATUS;
    endfunction : idx_mapped

    function automatic logic [7:0] read_reg(input top_state_t s, input logic [4:0] idx,
                                            input logic act_det, input logic deact_det);
        logic [7:0] r;
        r = 8'h00;
        case (idx)
            `IDX_PATTERN: begin
                r[`FLD_PATTERN +: 2] = s.pattern;
            end
            `IDX_LOOP_CTRL: begin
                r[3:0] = s.loop_ctrl;
            end
            `IDX_CODE_LEN: begin
                r[5:0] = s.code_len;
            end
            `IDX_TX_CODE: begin
                r = s.tx_code;
            end
            `IDX_ACT_CODE: begin
                r = s.act_code;
            end
            `IDX_DEACT_CODE: begin
                r = s.deact_code;
            end
            `IDX_STATUS: begin
                r[0] = act_det;
                r[1] = deact_det;
                r[2] = s.remote_loop;
            end
            default: begin
                r = 8'h00;
            end
        endcase
        return r;
    endfunction : read_reg

    // ----------------------------------------------------------------
    // line helpers
    // ----------------------------------------------------------------
    function automatic logic inband_bit(input logic [7:0] code, input logic [3:0] len,
                                        input logic [2:0] idx);
        return code[3'(len - 4'h1) - idx];
    endfunction : inband_bit

    function automatic logic [2:0] next_code_idx(input logic [2:0] idx, input logic [3:0] len);
        return ({1'b0, idx} == len - 4'h1) ? 3'h0 : idx + 3'h1;
    endfunction : next_code_idx

    // ----------------------------------------------------------------
    // code detectors
    // ----------------------------------------------------------------
    assign act_if.bit_en    = st.bit_en;
    assign act_if.rx_bit    = rx_line_data;
    assign act_if.code      = st.act_code;
    assign act_if.len_sel   = st.code_len[`FLD_ACT_LEN +: 2];
    assign deact_if.bit_en  = st.bit_en;
    assign deact_if.rx_bit  = rx_line_data;
    assign deact_if.code    = st.deact_code;
    assign deact_if.len_sel = st.code_len[`FLD_DEACT_LEN +: 2];

    inband_code_detect u_act_detect (
        .hclk    (hclk),
        .hresetn (hresetn),
        .det     (act_if.detector)
    );

    inband_code_detect u_deact_detect (
        .hclk    (hclk),
        .hresetn (hresetn),
        .det     (deact_if.detector)
    );

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        next_st    = st;
        addr_ok    = hsel && hready && htrans[`FLD_HTRANS_ACT];
        a_idx      = haddr[`FLD_WORD_IDX +: 5];
        auto_en    = st.loop_ctrl[`FLD_AUTO];
        tx_len     = code_len_of(st.code_len[`FLD_TX_LEN +: 2]);

        // ------------------------------------------------------------
        // bus data phase
        // ------------------------------------------------------------
        if (st.wr_pend) begin
            case (st.dp_idx)
                `IDX_PATTERN: begin
                    next_st.pattern = hwdata[`FLD_PATTERN +: 2];
                end
                `IDX_LOOP_CTRL: begin
                    next_st.loop_ctrl = hwdata[3:0];
                end
                `IDX_CODE_LEN: begin
                    next_st.code_len = hwdata[5:0];
                end
                `IDX_TX_CODE: begin
                    next_st.tx_code = hwdata[7:0];
                end
                `IDX_ACT_CODE: begin
                    next_st.act_code = hwdata[7:0];
                end
                `IDX_DEACT_CODE: begin
                    next_st.deact_code = hwdata[7:0];
                end
                default: begin
                    next_st.pattern = st.pattern;
                end
            endcase
        end
        next_st.wr_pend   = 1'b0;
        next_st.rd_pend   = 1'b0;
        next_st.hreadyout = 1'b1;
        next_st.hresp     = 1'b0;
        if (st.rd_pend) begin
            next_st.hrdata = st.dp_ok
                ? {24'h000000, read_reg(st, st.dp_idx, act_if.detected, deact_if.detected)}
                : 32'h00000000;
        end
        if (addr_ok) begin
            next_st.dp_idx  = a_idx;
            next_st.dp_ok   = haddr[31:`FLD_ADDR_TOP] == '0 && haddr[1:0] == 2'h0
                              && idx_mapped(a_idx);
            next_st.wr_pend = hwrite && next_st.dp_ok;
            next_st.rd_pend = !hwrite;
            if (!hwrite) begin
                next_st.hreadyout = 1'b0;
            end
        end

        // ------------------------------------------------------------
        // automatic remote loopback
        // ------------------------------------------------------------
        case (st.auto_state)
            LOOP_IDLE: begin
                if (auto_en && act_if.detected) begin
                    next_st.auto_state = LOOP_AUTO;
                end
            end
            LOOP_AUTO: begin
                if (!auto_en || deact_if.detected) begin
                    next_st.auto_state = LOOP_IDLE;
                end
            end
            default: begin
                next_st.auto_state = LOOP_IDLE;
            end
        endcase

        // ------------------------------------------------------------
        // loopback paths
        // ------------------------------------------------------------
        remote_now           = st.loop_ctrl[`FLD_REMOTE] || st.auto_state == LOOP_AUTO;
        next_st.remote_loop  = remote_now;
        next_st.digital_loop = st.loop_ctrl[`FLD_DIGITAL];
        next_st.analog_loop  = st.loop_ctrl[`FLD_ANALOG];
        next_st.rx_data_out  = st.loop_ctrl[`FLD_DIGITAL] ? tx_data_in : rx_line_data;

        // ------------------------------------------------------------
        // line bit timing
        // ------------------------------------------------------------
        next_st.bit_en = 1'b0;
        if (st.div_cnt == BIT_CYCLES - 3'h1) begin
            next_st.div_cnt = 3'h0;
            next_st.bit_en  = 1'b1;
        end else begin
            next_st.div_cnt = st.div_cnt + 3'h1;
        end

        // ------------------------------------------------------------
        // transmit stream, code sent msb first
        // ------------------------------------------------------------
        if (st.bit_en) begin
            if (remote_now) begin
                next_st.tx_line_data = rx_line_data;
                next_st.tx_idx       = 3'h0;
            end else if (st.pattern == `PATTERN_INBAND) begin
                next_st.tx_line_data = inband_bit(st.tx_code, tx_len, st.tx_idx);
                next_st.tx_idx       = next_code_idx(st.tx_idx, tx_len);
            end else if (st.pattern == `PATTERN_ALL_ONES) begin
                next_st.tx_line_data = 1'b1;
                next_st.tx_idx       = 3'h0;
            end else begin
                next_st.tx_line_data = tx_data_in;
                next_st.tx_idx       = 3'h0;
            end
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= ST_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign hreadyout               = st.hreadyout;
    assign hrdata                  = st.hrdata;
    assign hresp                   = st.hresp;
    assign tx_line_data            = st.tx_line_data;
    assign rx_data_out             = st.rx_data_out;
    assign digital_loopback_active = st.digital_loop;
    assign analog_loopback_active  = st.analog_loop;
    assign remote_loopback_active  = st.remote_loop;

endmodule : loopback_and_inband_code_config

// ### tb_loopback_and_inband_code_config.sv
`timescale 1ns/1ps
`include "lbc_defines.svh"
module tb_loopback_and_inband_code_config;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic        hwrite;
    logic        hreadyout;
    logic        hresp;
    logic        rx_line_data;
    logic        tx_data_in = 1'b0;
    logic        tx_line_data;
    logic        rx_data_out;
    logic        dig;
    logic        ana;
    logic        rem;
    logic        fe_send;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [3:0]  fe_len;
    logic [7:0]  fe_code;
    logic [15:0] s;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic [7:0]  wv [4] = '{8'hF1, 8'h02, 8'h04, 8'h00};
    logic [7:0]  cv [4] = '{8'h01, 8'hB3, 8'hB3, 8'hB3};
    int          n_mismatch = 0;
    int          n_compared = 0;

    loopback_and_inband_code_config dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .rx_line_data(rx_line_data), .tx_data_in(tx_data_in), .tx_line_data(tx_line_data),
        .rx_data_out(rx_data_out), .digital_loopback_active(dig), .analog_loopback_active(ana),
        .remote_loopback_active(rem)
    );
    far_end_line fe (
        .hclk(hclk), .hresetn(hresetn), .send(fe_send), .code(fe_code), .len(fe_len), .rx_line_data(rx_line_data)
    );

    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    // ----------------------------------------------------------------
    // system data toggle
    // ----------------------------------------------------------------
    always @(posedge hclk) begin
        tx_data_in <= ~tx_data_in;
    end

    function automatic logic [31:0] ad(input logic [4:0] i);
        return {25'h0, i, 2'h0};
    endfunction : ad

    function automatic logic rot_ok(input logic [15:0] v, input int l, input logic [7:0] c);
        logic ok;
        rot_ok = 1'b0;
        for (int k = 0; k < l; k++) begin
            ok = 1'b1;
            for (int i = 0; i < 8; i++) if (v[k+i] !== c[l-1-(i%l)]) ok = 1'b0;
            if (ok) rot_ok = 1'b1;
        end
    endfunction : rot_ok

    task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus

    task automatic wr(input logic [4:0] i, input logic [31:0] d);
        bus(ad(i), 1'b1, d);
    endtask : wr

    task automatic chk_reg(input logic [4:0] i, input logic [31:0] e);
        bus(ad(i), 1'b0, 32'h0);
        n_compared++;
        if (rd !== e) begin
            n_mismatch++;
            $display("wrong value at %0t: reg %h read %h expected %h", $time, i, rd, e);
        end
    endtask : chk_reg

    task automatic chk_flags(input logic [2:0] v, input logic [2:0] e);
        n_compared++;
        if (v !== e) begin
            n_mismatch++;
            $display("wrong value at %0t: flags %b expected %b", $time, v, e);
        end
    endtask : chk_flags

    task automatic give_verdict;
        $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : give_verdict

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        hsize = 3'h2;
        fe_send = 1'b0;
        fe_code = 8'h01;
        fe_len = 4'h5;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        fork
            run_tests();
            begin
                repeat (10000) @(posedge hclk);
                n_mismatch++;
            end
        join_any
        give_verdict();
    end

    task automatic run_tests;
        chk_reg(`IDX_LOOP_CTRL, 32'h00);
        chk_reg(`IDX_CODE_LEN, 32'h01);
        chk_reg(`IDX_TX_CODE, 32'h01);
        chk_reg(`IDX_ACT_CODE, 32'h01);
        chk_reg(`IDX_DEACT_CODE, 32'h09);
        for (int k = 0; k < 4; k++) begin
            wr(`IDX_LOOP_CTRL, {24'h0, wv[k]});
            chk_reg(`IDX_LOOP_CTRL, {28'h0, wv[k][3:0]});
            chk_flags({rem, ana, dig}, wv[k][2:0]);
            wr(`IDX_CODE_LEN, {26'h3, k[1:0], k[1:0], k[1:0]});
            chk_reg(`IDX_CODE_LEN, {26'h0, k[1:0], k[1:0], k[1:0]});
        end
        wr(5'h10, 32'hFF);
        chk_reg(5'h10, 32'h0);
        // line stream under the in-band pattern, each length
        for (int k = 0; k < 4; k++) begin
            wr(`IDX_TX_CODE, {24'h0, cv[k]});
            wr(`IDX_CODE_LEN, {26'h0, k[1:0], 4'h0});
            wr(`IDX_PATTERN, 32'h60);
            repeat (12) @(posedge hclk);
            for (int i = 0; i < 16; i++) begin
                s[i] = tx_line_data;
                repeat (4) @(posedge hclk);
            end
            chk_flags({2'b0, rot_ok(s, 5 + k, cv[k])}, 3'b001);
        end
        wr(`IDX_PATTERN, 32'h20);
        repeat (12) @(posedge hclk);
        chk_flags({2'b0, tx_line_data}, 3'b001);
        wr(`IDX_PATTERN, 32'h0);
        wr(`IDX_CODE_LEN, 32'h01);
        fe_send <= 1'b1;
        repeat (600) @(posedge hclk);
        chk_flags({rem, ana, dig}, 3'b000);
        chk_reg(`IDX_STATUS, 32'h01);
        wr(`IDX_LOOP_CTRL, 32'h08);
        repeat (600) @(posedge hclk);
        chk_flags({rem, ana, dig}, 3'b100);
        chk_reg(`IDX_STATUS, 32'h05);
        fe_code <= 8'h09;
        fe_len <= 4'h6;
        repeat (600) @(posedge hclk);
        chk_flags({rem, ana, dig}, 3'b000);
        chk_reg(`IDX_STATUS, 32'h02);
    endtask : run_tests
endmodule : tb_loopback_and_inband_code_config
